// >>> logic/aed_detector.sv
// ac (transient) acceleration event detector with its axi4-lite register slave
// assumes samples arrive on this clock with one strobe per output-data-rate period
//
// Notes on behaviour
// - bypass bit 0 filters the data, 1 passes raw data like motion detect
// - event when an enabled axis delta stays above threshold for debounce time
// - config enables z at bit 3, y bit 2, x bit 1; disabled never flags
// - latch bit 4 low: event flag follows the live detector condition
// - latch bit high: flag held until host reads the source register
// - source bit 6 is one while any axis flag is set
// - source axis flags at bits 5 z, 3 y, 1 x
// - polarity bits 4 z, 2 y, 0 x: 0 above positive, 1 below negative
// - latched mode freezes flags and polarity at the triggering event
// - non-latched mode keeps updating flags; only a source read clears them
// - config and source reset to zero; source read-only, bit 7 unused
// - debounce mode bit: 0 decrements counter, 1 clears it, when condition false
// - threshold is 7-bit unsigned, 63 mg per count at any range
// - 8-bit count is the least number of periods above threshold
`timescale 1ns/1ps
`include "aed_params.svh"
module aed_detector import aed_pkg::*; (
    input wire logic clock,
    input wire logic clock_en,
    input wire logic resetn,
    // acceleration samples, 1 mg per count
    input wire logic sample_valid,
    input wire aed_sample_t sample_x,
    input wire aed_sample_t sample_y,
    input wire aed_sample_t sample_z,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // event outputs
    output logic ac_event_flag,
    output logic irq
);
    // software registers
    aed_cfg_t cfg_q;
    aed_ths_t ths_q;
    logic [7:0] cnt_q;
    aed_src_t src_q;
    aed_src_t src_d;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_stat_d;
    logic [7:0] irq_mask_q;

    // write channel state
    logic aw_held_q;
    logic w_held_q;
    logic [9:0] aw_idx_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic wr_go;
    logic wr_known;

    // read channel state
    logic [9:0] ar_idx;
    logic rd_take;
    logic src_rd;
    logic [7:0] rd_byte;
    logic rd_known;

    // detector state
    aed_sample_t samples [3];
    aed_delta_t deltas [3];
    logic [2:0] axis_en;
    logic [2:0] filt_valid;
    logic [2:0] evt_stb;
    aed_axis_evt_t evts [3];
    logic [2:0] hits;
    logic [2:0] pols;
    logic det_stb;
    logic live_q;
    logic flag_d;

    assign samples[0] = sample_x;
    assign samples[1] = sample_y;
    assign samples[2] = sample_z;
    assign axis_en = {cfg_q.zen, cfg_q.yen, cfg_q.xen};

    // one filter and one debounce per axis, x first
    for (genvar a = 0; a < 3; a++) begin : g_axis
        aed_hpf u_hpf (
            .clock(clock),
            .clock_en(clock_en),
            .resetn(resetn),
            .in_valid(sample_valid),
            .in_sample(samples[a]),
            .bypass(cfg_q.hpf_byp),
            .out_delta(deltas[a]),
            .out_valid(filt_valid[a])
        );
        aed_debounce u_dbc (
            .clock(clock),
            .clock_en(clock_en),
            .resetn(resetn),
            .in_valid(filt_valid[a]),
            .delta(deltas[a]),
            .enable(axis_en[a]),
            .threshold(ths_q.ac_threshold_value),
            .count(cnt_q),
            .clear_mode(ths_q.debounce_clear_mode),
            .evt(evts[a]),
            .evt_stb(evt_stb[a])
        );
        assign hits[a] = evts[a].hit;
        assign pols[a] = evts[a].pol;
    end

    // all axes share the sample strobe, so axis x's strobe stands for all
    assign det_stb = evt_stb[0];

    // write decode: a write happens once both address and data are held
    assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
    always_comb begin
        unique case (aw_idx_q)
            `AED_IDX_CFG, `AED_IDX_SRC, `AED_IDX_THS, `AED_IDX_CNT,
            `AED_IDX_IRQ_STAT, `AED_IDX_IRQ_MASK: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // write address and data channels, taken in either order
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= '0;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
        end else if (clock_en) begin
            if (!aw_held_q && !s_axi_bvalid && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_held_q && !s_axi_bvalid && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_held_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_held_q <= 1'b1;
                wbyte_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AED_RESP_OKAY;
        end else if (clock_en) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `AED_RESP_OKAY : `AED_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers; only byte lane 0 carries data
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= `AED_CFG_RESET;
            ths_q <= `AED_THS_RESET;
            cnt_q <= `AED_CNT_RESET;
            irq_mask_q <= `AED_IRQ_RESET;
        end else if (clock_en && wr_go && wlane_q) begin
            unique case (aw_idx_q)
                `AED_IDX_CFG: cfg_q <= {3'h0, wbyte_q[4:0]};
                `AED_IDX_THS: ths_q <= wbyte_q;
                `AED_IDX_CNT: cnt_q <= wbyte_q;
                `AED_IDX_IRQ_MASK: irq_mask_q <= {7'h00, wbyte_q[`AED_IRQ_EVT]};
                default: ;
            endcase
        end
    end

    // read decode
    assign ar_idx = s_axi_araddr[11:2];
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign src_rd = rd_take && (ar_idx == `AED_IDX_SRC);
    always_comb begin
        rd_known = 1'b1;
        unique case (ar_idx)
            `AED_IDX_CFG: rd_byte = cfg_q;
            `AED_IDX_SRC: rd_byte = src_q;
            `AED_IDX_THS: rd_byte = ths_q;
            `AED_IDX_CNT: rd_byte = cnt_q;
            `AED_IDX_IRQ_STAT: rd_byte = irq_stat_q;
            `AED_IDX_IRQ_MASK: rd_byte = irq_mask_q;
            default: begin
                rd_byte = 8'h00;
                rd_known = 1'b0;
            end
        endcase
    end

    // read channel: data is captured in the same edge that clears the source
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `AED_RESP_OKAY;
        end else if (clock_en) begin
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_known ? `AED_RESP_OKAY : `AED_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // source register next value; a new event wins over a read clear
    always_comb begin
        src_d = src_q;
        if (src_rd) begin
            src_d = '0;
        end
        if (det_stb && |hits) begin
            if (cfg_q.ele) begin
                // only the first event after a clear is captured, then frozen
                if (!src_q.any_event_active || src_rd) begin
                    src_d.xef = hits[0];
                    src_d.xpol = hits[0] & pols[0];
                    src_d.yef = hits[1];
                    src_d.ypol = hits[1] & pols[1];
                    src_d.zef = hits[2];
                    src_d.zpol = hits[2] & pols[2];
                end
            end else begin
                // later events add axes and refresh their polarity
                if (hits[0]) begin
                    src_d.xef = 1'b1;
                    src_d.xpol = pols[0];
                end
                if (hits[1]) begin
                    src_d.yef = 1'b1;
                    src_d.ypol = pols[1];
                end
                if (hits[2]) begin
                    src_d.zef = 1'b1;
                    src_d.zpol = pols[2];
                end
            end
        end
        src_d.any_event_active = src_d.xef | src_d.yef | src_d.zef;
        src_d.unused = 1'b0;
    end

    // source register, read-only to software
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            src_q <= `AED_SRC_RESET;
        end else if (clock_en) begin
            src_q <= src_d;
        end
    end

    // live detector condition, refreshed once per sample
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            live_q <= 1'b0;
        end else if (clock_en && det_stb) begin
            live_q <= |hits;
        end
    end

    // event flag: held in latched mode, live otherwise
    assign flag_d = cfg_q.ele ? src_d.any_event_active :
                    (det_stb ? |hits : live_q);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ac_event_flag <= 1'b0;
        end else if (clock_en) begin
            ac_event_flag <= flag_d;
        end
    end

    // interrupt status: write one to clear, a high flag_d wins over the clear
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_go && wlane_q && aw_idx_q == `AED_IDX_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~wbyte_q;
        end
        if (flag_d) begin
            irq_stat_d[`AED_IRQ_EVT] = 1'b1;
        end
    end

    // interrupt line is a registered copy so it never glitches
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= `AED_IRQ_RESET;
            irq <= 1'b0;
        end else if (clock_en) begin
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end
endmodule // aed_detector

// >>> logic/aed_params.svh
// offsets, field positions, reset values and filter constants of the ac event detector
// assumes inclusion by bare name from every design file that needs them
`ifndef AED_PARAMS_SVH
`define AED_PARAMS_SVH

// register indices; byte address is four times the index
`define AED_IDX_CFG 10'h01D
`define AED_IDX_SRC 10'h01E
`define AED_IDX_THS 10'h01F
`define AED_IDX_CNT 10'h020
`define AED_IDX_IRQ_STAT 10'h040
`define AED_IDX_IRQ_MASK 10'h041

// reset values
`define AED_CFG_RESET 8'h00
`define AED_SRC_RESET 8'h00
`define AED_THS_RESET 8'h00
`define AED_CNT_RESET 8'h00
`define AED_IRQ_RESET 8'h00

// field positions
`define AED_CFG_HPF_BYP 0
`define AED_CFG_XEN 1
`define AED_CFG_YEN 2
`define AED_CFG_ZEN 3
`define AED_CFG_ELE 4
`define AED_SRC_EA 6
`define AED_THS_MODE 7
`define AED_IRQ_EVT 0

// threshold step in mg per count, samples arrive at 1 mg per count
`define AED_THS_STEP_MG 6'h3F
// high-pass corner: the baseline moves 1/16 of the gap each sample
`define AED_HPF_SHIFT 4

// axi responses
`define AED_RESP_OKAY 2'h0
`define AED_RESP_SLVERR 2'h2
`endif

// >>> logic/aed_pkg.sv
// types shared by the ac event detector files
// assumes the constants of aed_params.svh for bit positions
package aed_pkg;
    typedef logic signed [13:0] aed_sample_t;
    typedef logic signed [14:0] aed_delta_t;
    typedef struct packed {
        logic hit;
        logic pol;
    } aed_axis_evt_t;
    typedef struct packed {
        logic [2:0] unused;
        logic ele;
        logic zen;
        logic yen;
        logic xen;
        logic hpf_byp;
    } aed_cfg_t;
    typedef struct packed {
        logic unused;
        logic any_event_active;
        logic zef;
        logic zpol;
        logic yef;
        logic ypol;
        logic xef;
        logic xpol;
    } aed_src_t;
    typedef struct packed {
        logic debounce_clear_mode;
        logic [6:0] ac_threshold_value;
    } aed_ths_t;
endpackage

// >>> logic/aed_hpf.sv
// per-axis high-pass filter with bypass, one sample per strobe
// assumes samples and strobe come from logic on the same clock
`timescale 1ns/1ps
`include "aed_params.svh"
module aed_hpf import aed_pkg::*; (
    input wire logic clock,
    input wire logic clock_en,
    input wire logic resetn,
    input wire logic in_valid,
    input wire aed_sample_t in_sample,
    input wire logic bypass,
    output aed_delta_t out_delta,
    output logic out_valid
);
    aed_sample_t base_q;
    aed_delta_t diff;
    aed_delta_t step;

    // the baseline tracks dc; the difference is the ac part
    assign diff = aed_delta_t'(in_sample) - aed_delta_t'(base_q);
    assign step = diff >>> `AED_HPF_SHIFT;

    // baseline keeps tracking during bypass so switching back has no step
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            base_q <= '0;
            out_delta <= '0;
            out_valid <= 1'b0;
        end else if (clock_en) begin
            out_valid <= in_valid;
            if (in_valid) begin
                base_q <= aed_sample_t'(aed_delta_t'(base_q) + step);
                out_delta <= bypass ? aed_delta_t'(in_sample) : diff;
            end
        end
    end
endmodule // aed_hpf

// >>> logic/aed_debounce.sv
// per-axis threshold compare and debounce counter
// assumes one in_valid pulse per output-data-rate period
`timescale 1ns/1ps
`include "aed_params.svh"
module aed_debounce import aed_pkg::*; (
    input wire logic clock,
    input wire logic clock_en,
    input wire logic resetn,
    input wire logic in_valid,
    input wire aed_delta_t delta,
    input wire logic enable,
    input wire logic [6:0] threshold,
    input wire logic [7:0] count,
    input wire logic clear_mode,
    output aed_axis_evt_t evt,
    output logic evt_stb
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_up;
    logic [14:0] mag;
    logic [12:0] limit;
    logic cond;

    // threshold is unsigned counts of a fixed 63 mg step
    assign limit = 13'(threshold * `AED_THS_STEP_MG);
    assign mag = delta[14] ? 15'(-delta) : 15'(delta);
    assign cond = enable && (mag > 15'(limit));
    assign cnt_up = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;

    // counter saturates so a long event never wraps back to zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            evt <= '0;
            evt_stb <= 1'b0;
        end else if (clock_en) begin
            evt_stb <= in_valid;
            if (in_valid) begin
                if (cond) begin
                    cnt_q <= cnt_up;
                    evt.hit <= (cnt_up >= count);
                    evt.pol <= delta[14];
                end else begin
                    cnt_q <= (clear_mode || !enable || cnt_q == 8'h00) ? 8'h00
                             : cnt_q - 8'h01;
                    evt.hit <= 1'b0;
                end
            end
        end
    end
endmodule // aed_debounce

// >>> verification/aed_detector_assertions.sv
// concurrent checks on the ports of the ac event detector
// assumes one clock domain and a bind placed in the bench top file
`timescale 1ns/1ps
`include "aed_params.svh"
module aed_detector_assertions (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sample_valid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ac_event_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic src_rd_q;
    // remembers whether the read in flight targets the source register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            src_rd_q <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            src_rd_q <= (s_axi_araddr == {`AED_IDX_SRC, 2'b00});
        end
    end
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    property p_b_hold;
        s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_b_cause;
        $rose(s_axi_bvalid) |-> !$past(s_axi_wready) && !s_axi_wready;
    endproperty
    a_b_cause: assert property (p_b_cause) else $error("write response without data");
    property p_r_cause;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
    endproperty
    a_r_cause: assert property (p_r_cause) else $error("read data without address");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == `AED_RESP_SLVERR |-> s_axi_rdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read carries data");
    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    // summary bit must agree with the axis flags, bit 7 never set
    property p_src_any;
        s_axi_rvalid && src_rd_q |->
            s_axi_rdata[6] == (s_axi_rdata[5] | s_axi_rdata[3] | s_axi_rdata[1]) && !s_axi_rdata[7];
    endproperty
    a_src_any: assert property (p_src_any) else $error("summary bit wrong");
    property p_flag_rise;
        $rose(ac_event_flag) |-> $past(sample_valid, 3) || $past(sample_valid, 4);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag rose off a sample");
endmodule // aed_detector_assertions

// >>> verification/aed_accel_model.sv
// sensor front end model: one sample strobe per output-data-rate period
// assumes the bench sets the axis values between strobes
`timescale 1ns/1ps
module aed_accel_model import aed_pkg::*; #(
    parameter int PERIOD = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire aed_sample_t ax,
    input wire aed_sample_t ay,
    input wire aed_sample_t az,
    output logic sample_valid,
    output aed_sample_t sample_x,
    output aed_sample_t sample_y,
    output aed_sample_t sample_z
);
    int cnt_q;
    // free-running period counter, strobe on wrap
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 0;
            sample_valid <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            sample_valid <= (cnt_q == PERIOD - 1);
        end
    end
    // values mean nothing off the strobe, so show their inverse to catch stray reads
    assign sample_x = sample_valid ? ax : ~ax;
    assign sample_y = sample_valid ? ay : ~ay;
    assign sample_z = sample_valid ? az : ~az;
endmodule // aed_accel_model

// >>> verification/aed_detector_tb.sv
// self-checking bench for the ac event detector through its axi4-lite slave
// assumes the sensor model for samples and the checker bound at the foot
`timescale 1ns/1ps
`include "aed_params.svh"
`define TB_CHK(a, b) chk(32'(a), 32'(b))
module aed_detector_tb import aed_pkg::*;;
    localparam logic [11:0] A_CFG = {`AED_IDX_CFG, 2'b00};
    localparam logic [11:0] A_SRC = {`AED_IDX_SRC, 2'b00};
    localparam logic [11:0] A_THS = {`AED_IDX_THS, 2'b00};
    localparam logic [11:0] A_CNT = {`AED_IDX_CNT, 2'b00};
    localparam logic [11:0] A_STAT = {`AED_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MASK = {`AED_IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_BAD = 12'hFFC;
    localparam logic [1:0] OK = `AED_RESP_OKAY;
    localparam logic [1:0] ERR = `AED_RESP_SLVERR;
    logic clock, clock_en, resetn, sample_valid, ac_event_flag, irq;
    aed_sample_t ax, ay, az, sample_x, sample_y, sample_z;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    aed_accel_model #(.PERIOD(8)) sensor (.clock, .resetn, .ax, .ay, .az, .sample_valid,
        .sample_x, .sample_y, .sample_z);
    aed_detector dut (.clock, .clock_en, .resetn, .sample_valid, .sample_x, .sample_y,
        .sample_z, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ac_event_flag, .irq);
    // 25 mhz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the fewer than a thousand cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // each channel is released at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [1:0] e);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'hA5A5A5, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end while (s_axi_bvalid !== 1'b1);
        // late ready makes the answer stand a cycle
        s_axi_bready <= 1'b1;
        @(posedge clock);
        s_axi_bready <= 1'b0;
        `TB_CHK(s_axi_bresp, e);
        @(posedge clock);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [1:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge clock);
        s_axi_rready <= 1'b0;
        `TB_CHK(s_axi_rdata, x);
        `TB_CHK(s_axi_rresp, e);
        @(posedge clock);
    endtask
    task automatic set(input aed_sample_t x, input aed_sample_t y, input aed_sample_t z);
        ax <= x;
        ay <= y;
        az <= z;
    endtask
    // flag settles three edges after the strobe is taken; six leaves margin
    task automatic wait_samples(input int n);
        repeat (n) @(posedge sample_valid);
        repeat (6) @(posedge clock);
    endtask
    initial begin
        resetn = 1'b0;
        clock_en = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 34'h0;
        s_axi_wdata = 32'h0;
        {ax, ay, az} = 42'h0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        // reset values, refused and ignored accesses
        rd(A_CFG, 32'h00, OK);
        rd(A_SRC, 32'h00, OK);
        rd(A_BAD, 32'h00, ERR);
        wr(A_BAD, 8'hFF, 4'hF, ERR);
        wr(A_SRC, 8'hFF, 4'hF, OK);
        rd(A_SRC, 32'h00, OK);
        wr(A_CFG, 8'hFF, 4'hF, OK);
        rd(A_CFG, 32'h1F, OK);
        wr(A_CFG, 8'h00, 4'h0, OK);
        rd(A_CFG, 32'h1F, OK);
        // latched: x just over 126 mg, y disabled, later z must not join
        wr(A_THS, 8'h82, 4'hF, OK);
        wr(A_CNT, 8'h03, 4'hF, OK);
        wr(A_CFG, 8'h1B, 4'hF, OK);
        set(127, 200, 0);
        wait_samples(2);
        `TB_CHK(ac_event_flag, 1'b0);
        wait_samples(1);
        `TB_CHK(ac_event_flag, 1'b1);
        set(127, 200, -200);
        wait_samples(3);
        set(0, 0, 0);
        wait_samples(1);
        `TB_CHK(ac_event_flag, 1'b1);
        rd(A_SRC, 32'h42, OK);
        rd(A_SRC, 32'h00, OK);
        repeat (3) @(posedge clock);
        `TB_CHK(ac_event_flag, 1'b0);
        // sticky status, masked then unmasked, cleared by writing one
        `TB_CHK(irq, 1'b0);
        wr(A_MASK, 8'h01, 4'hF, OK);
        repeat (3) @(posedge clock);
        `TB_CHK(irq, 1'b1);
        rd(A_STAT, 32'h01, OK);
        wr(A_STAT, 8'h01, 4'hF, OK);
        repeat (3) @(posedge clock);
        `TB_CHK(irq, 1'b0);
        rd(A_STAT, 32'h00, OK);
        // live mode: y at 126 stays quiet, polarity refreshed by later hits
        wr(A_CNT, 8'h01, 4'hF, OK);
        wr(A_CFG, 8'h0F, 4'hF, OK);
        set(-127, 126, 0);
        wait_samples(1);
        `TB_CHK(ac_event_flag, 1'b1);
        set(127, -200, 300);
        wait_samples(1);
        set(0, 0, 0);
        wait_samples(1);
        `TB_CHK(ac_event_flag, 1'b0);
        rd(A_SRC, 32'h6E, OK);
        rd(A_SRC, 32'h00, OK);
        // debounce mode: decrement lets above-above-below-above-above reach three
        wr(A_CNT, 8'h03, 4'hF, OK);
        for (int m = 0; m < 2; m++) begin
            wr(A_CFG, 8'h00, 4'hF, OK);
            wr(A_THS, {m[0], 7'h02}, 4'hF, OK);
            wr(A_CFG, 8'h03, 4'hF, OK);
            for (int i = 0; i < 5; i++) begin
                set((i == 2) ? 14'sd0 : 14'sd200, 0, 0);
                wait_samples(1);
            end
            set(0, 0, 0);
            rd(A_SRC, (m == 0) ? 32'h42 : 32'h00, OK);
        end
        // filter on: a steady offset decays below threshold, bypass restores it
        wr(A_CNT, 8'h01, 4'hF, OK);
        wr(A_CFG, 8'h02, 4'hF, OK);
        set(500, 0, 0);
        wait_samples(40);
        `TB_CHK(ac_event_flag, 1'b0);
        wr(A_CFG, 8'h03, 4'hF, OK);
        wait_samples(1);
        `TB_CHK(ac_event_flag, 1'b1);
        end_of_test();
    end
endmodule // aed_detector_tb
bind aed_detector aed_detector_assertions chk_i (.clock, .resetn, .sample_valid, .s_axi_araddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ac_event_flag);
